// ===== logic/clp_ctrl.sv
// clock module and low-power mode controller
//
// Functional notes
// - pll multiplies the reference by fixed four
// - crystal mode: internal oscillator forms 5 MHz base
// - external mode: oscillator bypassed, pin drives reference
// - cpu domain and system domain from pll output
// - light idle stops cpu, clock output runs
// - mode bits 13:12: 00 light, 01 deep, 1x halt
// - deep idle stops both domains, watchdog keeps running
// - halt powers down oscillator, pll, watchdog; reset exits
// - light idle ends on reset or any external, wakeup or enabled peripheral interrupt
// - reset ends idle; halt exit waits oscillator stable
// - external pins wake light and deep, not halt
// - deep idle: unclocked detect, restart, then request
// - power drive protect counts as external interrupt
// - wakeup peripherals restart clocks and end deep idle
// - enabled peripheral irq ends light idle only
`default_nettype none
module clp_ctrl
	import clp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// oscillator pins
	input wire logic ext_clock_mode,
	input wire logic clock_input_pin,
	output logic crystal_drive_pin,
	// cpu side
	input wire logic idle_exec,
	input wire logic [15:0] system_control_register,
	input wire logic reset_req,
	input wire logic global_irq_en,
	output logic cpu_hold_reset,
	// wake sources
	input wire logic [1:0] external_irq_pin,
	input wire logic power_drive_protect_irq,
	input wire logic periph_irq_req,
	input wire logic wakeup_irq_req,
	// clocks out
	output clp_clk_en_t clk_en,
	output logic cpu_clock_output,
	output logic pll_locked,
	output logic osc_running,
	output clp_state_t lp_state,
	// interrupt expansion controller side
	output logic wake_async,
	output clp_ext_irq_t iec_ext_irq
);
	clp_state_t state_q;
	logic [1:0] lowpower_select_field;
	logic [7:0] xtal_cnt_q;
	logic osc_run;
	logic ref_prev_q;
	logic ref_edge;
	logic ref_level;
	logic [7:0] per_cnt_q;
	logic [7:0] period_q;
	logic [1:0] edges_q;
	logic [8:0] acc_q;
	logic [8:0] acc_sum;
	logic pll_tick;
	logic [7:0] wdog_cnt_q;
	logic wdog_tick;
	logic [11:0] osc_wait_q;
	logic ext_any;
	logic [2:0] ext_pins;
	logic [2:0] ext_prev_q;
	logic [2:0] ext_rise;
	logic [2:0] pend_q;
	logic send_ok;
	logic cpu_en;
	logic sys_en;
	logic wdog_en;

	assign lowpower_select_field = system_control_register[LPSEL_LSB +: 2];
	assign osc_run = (state_q != CLP_HALT);
	assign osc_running = osc_run;
	assign lp_state = state_q;
	assign cpu_hold_reset = (state_q == CLP_OSC_WAIT);

	// internal oscillator at the crystal rate
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			xtal_cnt_q <= 8'h0000;
		end else if (!osc_run || ext_clock_mode) begin
			xtal_cnt_q <= 8'h0000;
		end else if (xtal_cnt_q == XTAL_DIV - 8'h0001) begin
			xtal_cnt_q <= 8'h0000;
		end else begin
			xtal_cnt_q <= xtal_cnt_q + 8'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			crystal_drive_pin <= 1'b0;
		end else begin
			crystal_drive_pin <= osc_run && !ext_clock_mode && (xtal_cnt_q >= XTAL_HIGH);
		end
	end

	// reference comes from the pin in external mode, bypassing the oscillator
	assign ref_level = ext_clock_mode ? clock_input_pin : (xtal_cnt_q < XTAL_HIGH);
	assign ref_edge = osc_run && ref_level && !ref_prev_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ref_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= ref_level && osc_run;
		end
	end

	// pll: measure the reference period, then spread four ticks over it
	always_ff @(posedge clk_sys) begin
		if (srst || !osc_run) begin
			per_cnt_q <= 8'h0000;
			period_q <= PERIOD_RST;
			edges_q <= 2'h0;
		end else if (ref_edge) begin
			per_cnt_q <= 8'h0001;
			period_q <= per_cnt_q;
			if (edges_q != LOCK_EDGES) begin
				edges_q <= edges_q + 2'h1;
			end
		end else if (per_cnt_q != 8'h00ff) begin
			per_cnt_q <= per_cnt_q + 8'h0001;
		end
	end

	assign pll_locked = (edges_q == LOCK_EDGES) && (period_q >= 8'(PLL_MULT));
	assign acc_sum = acc_q + 9'(PLL_MULT);
	assign pll_tick = pll_locked && (acc_sum >= {1'b0, period_q});

	always_ff @(posedge clk_sys) begin
		if (srst || !pll_locked) begin
			acc_q <= 9'h0000;
		end else if (ref_edge) begin
			acc_q <= 9'h0000;
		end else if (pll_tick) begin
			acc_q <= acc_sum - {1'b0, period_q};
		end else begin
			acc_q <= acc_sum;
		end
	end

	// watchdog clock from the pll, absent in halt and until the pll locks
	always_ff @(posedge clk_sys) begin
		if (srst || !pll_locked) begin
			wdog_cnt_q <= 8'h0000;
		end else if (pll_tick) begin
			wdog_cnt_q <= (wdog_cnt_q == WDOG_DIV - 8'h0001) ? 8'h0000 : wdog_cnt_q + 8'h0001;
		end
	end

	assign wdog_tick = pll_tick && (wdog_cnt_q == 8'h0000);

	// external wake sources, power drive protect among them
	assign ext_pins = {external_irq_pin[0], external_irq_pin[1], power_drive_protect_irq};
	// unclocked detect used while the domains are stopped
	assign ext_any = |ext_pins;
	assign wake_async = (state_q == CLP_DEEP) && (ext_any || wakeup_irq_req);

	// low-power state machine
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= CLP_OSC_WAIT;
		end else begin
			case (state_q)
				CLP_RUN: begin
					if (reset_req) begin
						state_q <= CLP_RUN;
					end else if (idle_exec) begin
						if (lowpower_select_field[1]) begin
							state_q <= CLP_HALT;
						end else if (lowpower_select_field == LPSEL_DEEP) begin
							state_q <= CLP_DEEP;
						end else begin
							state_q <= CLP_LIGHT;
						end
					end
				end
				CLP_LIGHT: begin
					if (reset_req || ext_any || wakeup_irq_req ||
						(periph_irq_req && global_irq_en)) begin
						state_q <= CLP_RUN;
					end
				end
				CLP_DEEP: begin
					// plain peripheral requests cannot end deep idle
					if (reset_req || wake_async) begin
						state_q <= CLP_RUN;
					end
				end
				CLP_HALT: begin
					if (reset_req) begin
						state_q <= CLP_OSC_WAIT;
					end
				end
				CLP_OSC_WAIT: begin
					if (osc_wait_q == OSC_STABLE_CYC && pll_locked) begin
						state_q <= CLP_RUN;
					end
				end
				default: begin
					state_q <= CLP_OSC_WAIT;
				end
			endcase
		end
	end

	// oscillator stabilisation count
	always_ff @(posedge clk_sys) begin
		if (srst || state_q != CLP_OSC_WAIT) begin
			osc_wait_q <= 12'h0000;
		end else if (osc_wait_q != OSC_STABLE_CYC) begin
			osc_wait_q <= osc_wait_q + 12'h0001;
		end
	end

	// domain run requests
	assign cpu_en = (state_q == CLP_RUN);
	assign sys_en = (state_q == CLP_RUN) || (state_q == CLP_LIGHT);
	assign wdog_en = (state_q != CLP_HALT);

	clp_gate_cell u_gate_cpu (
		.clk_sys(clk_sys),
		.srst(srst),
		.tick(pll_tick),
		.run_req(cpu_en),
		.clk_en(clk_en.cpu)
	);

	clp_gate_cell u_gate_sys (
		.clk_sys(clk_sys),
		.srst(srst),
		.tick(pll_tick),
		.run_req(sys_en),
		.clk_en(clk_en.sys)
	);

	clp_gate_cell u_gate_wdog (
		.clk_sys(clk_sys),
		.srst(srst),
		.tick(wdog_tick),
		.run_req(wdog_en),
		.clk_en(clk_en.wdog)
	);

	// the cpu clock output is the system domain clock
	assign cpu_clock_output = clk_en.sys;

	// clocked request path toward the expansion controller
	assign ext_rise = ext_pins & ~ext_prev_q;
	assign send_ok = clk_en.sys && (state_q == CLP_RUN);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ext_prev_q <= 3'h0;
		end else begin
			ext_prev_q <= ext_pins;
		end
	end

	// a new edge wins over the clear of the same cycle; halt ignores pins
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pend_q <= 3'h0;
		end else if (state_q == CLP_HALT || state_q == CLP_OSC_WAIT) begin
			pend_q <= 3'h0;
		end else begin
			pend_q <= (send_ok ? 3'h0 : pend_q) | ext_rise;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			iec_ext_irq <= '0;
		end else begin
			iec_ext_irq <= send_ok ? pend_q : 3'h0;
		end
	end

	// helper: pll ticks counted between reference edges
	logic [3:0] tick_cnt_q;
	always_ff @(posedge clk_sys) begin
		if (srst || !pll_locked) begin
			tick_cnt_q <= 4'h0;
		end else if (ref_edge) begin
			tick_cnt_q <= 4'h0;
		end else if (pll_tick) begin
			tick_cnt_q <= tick_cnt_q + 4'h1;
		end
	end

	pll_four_ticks_a: assert property (@(posedge clk_sys) disable iff (srst)
		(ref_edge && pll_locked && $past(pll_locked) && $stable(period_q))
		|-> (tick_cnt_q + 4'(pll_tick) == 4'(PLL_MULT)))
		else $error("pll tick count per reference period wrong");
	mode_select_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state_q == CLP_RUN && idle_exec && !reset_req) |=>
		(state_q == (lowpower_select_field[1] ? CLP_HALT :
		(lowpower_select_field[0] ? CLP_DEEP : CLP_LIGHT))))
		else $error("wrong low-power state entered");
	light_cpu_off_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state_q == CLP_LIGHT) [*5] |-> !clk_en.cpu)
		else $error("cpu clock running in light idle");
	light_sys_on_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state_q == CLP_LIGHT && $past(state_q) == CLP_LIGHT && pll_tick) |-> cpu_clock_output)
		else $error("clock output stopped in light idle");
	deep_sys_off_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state_q == CLP_DEEP) [*5] |-> (!clk_en.sys && !clk_en.cpu && osc_running))
		else $error("domain running in deep idle");
	halt_osc_off_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state_q == CLP_HALT && !reset_req) |=> (state_q == CLP_HALT && !osc_running
		&& !pll_locked && !clk_en.wdog))
		else $error("halt left without reset");
	light_irq_exit_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state_q == CLP_LIGHT && (ext_any || (periph_irq_req && global_irq_en))) |=>
		(state_q == CLP_RUN))
		else $error("light idle not left on interrupt");
	deep_periph_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state_q == CLP_DEEP && !reset_req && !wake_async) |=> (state_q == CLP_DEEP))
		else $error("deep idle left without wake source");
	osc_wait_len_a: assert property (@(posedge clk_sys) disable iff (srst)
		($rose(cpu_hold_reset) && !pll_locked) |-> cpu_hold_reset [*8])
		else $error("cpu reset released before oscillator settled");
	deep_req_late_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state_q == CLP_DEEP) |-> (iec_ext_irq == 3'h0))
		else $error("request raised while clocks stopped");

	halt_cover_c: cover property (@(posedge clk_sys) disable iff (srst)
		state_q == CLP_HALT ##1 state_q == CLP_OSC_WAIT);
	deep_wake_c: cover property (@(posedge clk_sys) disable iff (srst)
		state_q == CLP_DEEP && wake_async);
	light_wake_c: cover property (@(posedge clk_sys) disable iff (srst)
		state_q == CLP_LIGHT ##1 state_q == CLP_RUN);
endmodule : clp_ctrl
`default_nettype wire

// ===== logic/clp_gate_cell.sv
// glitch-free enable gate for one clock domain
`default_nettype none
module clp_gate_cell
	import clp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// control
	input wire logic tick,
	input wire logic run_req,
	// gated domain enable
	output logic clk_en
);
	logic gate_q;

	// the gate only moves between ticks, so no pulse is ever cut short
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			gate_q <= 1'b0;
		end else if (!tick) begin
			gate_q <= run_req;
		end
	end

	assign clk_en = tick & gate_q;
endmodule : clp_gate_cell
`default_nettype wire

// ===== shared/clp_pkg.sv
// shared constants and carrier types of the clock and low-power controller
`default_nettype none
package clp_pkg;
	localparam int unsigned CLK_SYS_NS = 40;
	// pll multiplication is fixed, nothing can change it
	localparam logic [3:0] PLL_MULT = 4'h4;
	// crystal reference, 5 MHz
	localparam int unsigned XTAL_NS = 200;
	localparam logic [7:0] XTAL_DIV = 8'(XTAL_NS / CLK_SYS_NS);
	localparam logic [7:0] XTAL_HIGH = 8'(XTAL_DIV / 2);
	// oscillator restart time after halt
	localparam int unsigned OSC_STABLE_NS = 10000;
	localparam logic [11:0] OSC_STABLE_CYC =
		12'((OSC_STABLE_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
	// watchdog clock is the pll clock divided down
	localparam logic [7:0] WDOG_DIV = 8'h0040;
	// mode field position in the system control register
	localparam int unsigned LPSEL_LSB = 12;
	localparam logic [1:0] LPSEL_LIGHT = 2'h0;
	localparam logic [1:0] LPSEL_DEEP = 2'h1;
	localparam logic [7:0] PERIOD_RST = 8'h0000;
	localparam logic [1:0] LOCK_EDGES = 2'h2;

	typedef enum logic [2:0] {
		CLP_RUN,
		CLP_LIGHT,
		CLP_DEEP,
		CLP_HALT,
		CLP_OSC_WAIT
	} clp_state_t;

	typedef struct packed {
		logic cpu;
		logic sys;
		logic wdog;
	} clp_clk_en_t;

	typedef struct packed {
		logic xint1;
		logic xint2;
		logic pdp;
	} clp_ext_irq_t;
endpackage : clp_pkg
`default_nettype wire

// ===== sim/clp_ref_model.sv
// reference source model: crystal feedback or free-running external oscillator
`default_nettype none
module clp_ref_model (
	// mode
	input wire logic ext_clock_mode,
	// crystal side
	input wire logic crystal_drive_pin,
	// pin to the device
	output logic clock_input_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic osc = 1'b0;
	// 5 MHz oscillator, phase kept off the system clock edges
	initial begin
		#7;
		forever #100 osc = ~osc;
	end
	// crystal resonates at the drive phase, external oscillator runs free
	assign clock_input_pin = ext_clock_mode ? osc : crystal_drive_pin;
endmodule : clp_ref_model
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench of the clock and low-power controller
`default_nettype none
module tb_top
	import clp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, srst = 1'b1, ext_clock_mode = 1'b0, idle_exec = 1'b0;
	logic reset_req = 1'b0, global_irq_en = 1'b0, power_drive_protect_irq = 1'b0;
	logic periph_irq_req = 1'b0, wakeup_irq_req = 1'b0;
	logic [15:0] system_control_register = 16'h0000;
	logic [1:0] external_irq_pin = 2'h0;
	logic clock_input_pin, crystal_drive_pin, cpu_hold_reset, cpu_clock_output;
	logic pll_locked, osc_running, wake_async;
	clp_clk_en_t clk_en;
	clp_state_t lp_state;
	clp_ext_irq_t iec_ext_irq;
	int mismatches = 0, cmp_count = 0, n_cpu, n_sys, n_wd;

	always #20 clk_sys = ~clk_sys;

	clp_ref_model i_clp_ref_model (.ext_clock_mode, .crystal_drive_pin, .clock_input_pin);
	clp_ctrl i_clp_ctrl (.clk_sys, .srst, .ext_clock_mode, .clock_input_pin,
		.crystal_drive_pin, .idle_exec, .system_control_register, .reset_req,
		.global_irq_en, .cpu_hold_reset, .external_irq_pin, .power_drive_protect_irq,
		.periph_irq_req, .wakeup_irq_req, .clk_en, .cpu_clock_output, .pll_locked,
		.osc_running, .lp_state, .wake_async, .iec_ext_irq);

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_st(input clp_state_t s, input int lim);
		for (int i = 0; i < lim && lp_state !== s; i++)
			@(negedge clk_sys);
		chk(16'(lp_state), 16'(s));
		if (lp_state !== s) begin
			test_done();
		end
	endtask : wait_st

	// counts domain pulses over n cycles, clock output must mirror the system enable
	task automatic count(input int n);
		n_cpu = 0;
		n_sys = 0;
		n_wd = 0;
		repeat (n) begin
			@(negedge clk_sys);
			n_cpu += int'(clk_en.cpu);
			n_sys += int'(clk_en.sys);
			n_wd += int'(clk_en.wdog);
			chk(16'(cpu_clock_output), 16'(clk_en.sys));
		end
	endtask : count

	// other register bits set so that only the mode field may matter
	task automatic enter(input logic [1:0] m, input clp_state_t s);
		system_control_register = {2'h3, m, 12'hfff};
		idle_exec = 1'b1;
		@(negedge clk_sys);
		idle_exec = 1'b0;
		wait_st(s, 3);
		repeat (3) @(negedge clk_sys);
	endtask : enter

	task automatic t_reset();
		chk(16'(cpu_hold_reset), 16'h0001);
		wait_st(CLP_RUN, 600);
		chk(16'({pll_locked, osc_running}), 16'h0003);
		// a gate opens only on a cycle without a tick, up to five cycles late
		repeat (5) @(negedge clk_sys);
		count(50);
		chk(16'(n_sys), 16'h0028);
		chk(16'(n_cpu), 16'h0028);
		$display("reset and pll test done");
	endtask : t_reset

	task automatic t_light();
		enter(2'h0, CLP_LIGHT);
		count(20);
		chk(16'(n_cpu), 16'h0000);
		chk(16'(n_sys), 16'h0010);
		periph_irq_req = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk(16'(lp_state), 16'(CLP_LIGHT));
		global_irq_en = 1'b1;
		wait_st(CLP_RUN, 3);
		periph_irq_req = 1'b0;
		enter(2'h0, CLP_LIGHT);
		wakeup_irq_req = 1'b1;
		wait_st(CLP_RUN, 3);
		wakeup_irq_req = 1'b0;
		enter(2'h0, CLP_LIGHT);
		reset_req = 1'b1;
		repeat (3) @(negedge clk_sys);
		reset_req = 1'b0;
		chk(16'(lp_state != CLP_LIGHT), 16'h0001);
		wait_st(CLP_RUN, 600);
		$display("light idle test done");
	endtask : t_light

	task automatic t_deep();
		logic [2:0] got;
		enter(2'h1, CLP_DEEP);
		periph_irq_req = 1'b1;
		count(200);
		chk(16'(n_cpu + n_sys), 16'h0000);
		chk(16'(n_wd != 0), 16'h0001);
		chk(16'(lp_state), 16'(CLP_DEEP));
		periph_irq_req = 1'b0;
		for (int i = 0; i < 3; i++) begin
			enter(2'h1, CLP_DEEP);
			{power_drive_protect_irq, external_irq_pin} = 3'h1 << i;
			#1;
			chk(16'(wake_async), 16'h0001);
			wait_st(CLP_RUN, 3);
			got = 3'h0;
			repeat (20) begin
				@(negedge clk_sys);
				got |= iec_ext_irq;
			end
			chk(16'(got), 16'(3'h4 >> i));
			{power_drive_protect_irq, external_irq_pin} = 3'h0;
		end
		enter(2'h1, CLP_DEEP);
		wakeup_irq_req = 1'b1;
		wait_st(CLP_RUN, 3);
		wakeup_irq_req = 1'b0;
		$display("deep idle test done");
	endtask : t_deep

	task automatic t_halt();
		int n;
		for (int i = 2; i < 4; i++) begin
			enter(2'(i), CLP_HALT);
			external_irq_pin = 2'h3;
			wakeup_irq_req = 1'b1;
			count(20);
			chk(16'({osc_running, crystal_drive_pin, pll_locked, wake_async}), 16'h0000);
			chk(16'(n_wd + n_sys + n_cpu), 16'h0000);
			chk(16'(lp_state), 16'(CLP_HALT));
			external_irq_pin = 2'h0;
			wakeup_irq_req = 1'b0;
			reset_req = 1'b1;
			@(negedge clk_sys);
			reset_req = 1'b0;
			wait_st(CLP_OSC_WAIT, 3);
			n = 0;
			while (cpu_hold_reset === 1'b1 && n < 600) begin
				@(negedge clk_sys);
				n++;
			end
			chk(16'(n >= int'(OSC_STABLE_CYC)), 16'h0001);
			wait_st(CLP_RUN, 5);
		end
		$display("halt test done");
	endtask : t_halt

	task automatic t_ext();
		ext_clock_mode = 1'b1;
		srst = 1'b1;
		repeat (6) @(negedge clk_sys);
		srst = 1'b0;
		wait_st(CLP_RUN, 600);
		repeat (5) @(negedge clk_sys);
		count(50);
		chk(16'(n_sys), 16'h0028);
		chk(16'(crystal_drive_pin), 16'h0000);
		$display("external clock test done");
	endtask : t_ext

	initial begin
		repeat (6) @(negedge clk_sys);
		srst = 1'b0;
		t_reset();
		t_light();
		t_deep();
		t_halt();
		t_ext();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
